// ==== pot_map.svh ====
// Constants of the potentiometer serial command controller
`ifndef POT_MAP_SVH
`define POT_MAP_SVH

// ==========================================================
// Command bytes, first byte of a frame, top bit first
`define POT_CMD_WR_WIPER 8'h00
`define POT_CMD_WR_NV 8'h10
`define POT_CMD_CP_W2NV 8'h20
`define POT_CMD_CP_NV2W 8'h30
`define POT_CMD_RD_NV 8'h28
`define POT_CMD_RD_WIPER 8'h68

// ==========================================================
// Frame lengths and read sequencing
`define POT_LEN_SHORT 5'h08
`define POT_LEN_LONG 5'h10
`define POT_LEN_SAT 5'h11
`define POT_TX_FIRST 4'h2
`define POT_TX_LAST 4'h9
`define POT_TX_SLEEP 4'hb

// ==========================================================
// Values and timing
`define POT_FACTORY_POS 8'h80
`define POT_CLK_PS 8000
`define POT_PU_US 5
`define POT_PU_CYC ((`POT_PU_US * 1000000 + `POT_CLK_PS - 1) / `POT_CLK_PS)
`define POT_PU_W 10
`define POT_BUSY_MS 20
`define POT_BUSY_CYC ((`POT_BUSY_MS * 1000000) / (`POT_CLK_PS / 1000))
`define POT_BUSY_W 22

`endif

// ==== pot_pkg.sv ====
// Types of the potentiometer serial command controller
`include "pot_map.svh"

package pot_pkg;

  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_RX, ST_TX} pot_state_t;

  typedef struct packed {
    pot_state_t state;
    logic [15:0] shreg;
    logic [4:0] bitcnt;
    logic [7:0] wiper;
    logic [7:0] nv;
    logic busy;
    logic [`POT_BUSY_W-1:0] busycnt;
    logic [`POT_PU_W-1:0] pucnt;
    logic [7:0] txreg;
    logic [3:0] txcnt;
    logic sdo;
    logic oe;
    logic standby;
  } pot_regs_t;

endpackage: pot_pkg

// ==== pot_sync.sv ====
// Two-flop synchroniser with edge detection for the serial pins
module pot_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [W-1:0] pins_i,
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);

  logic [W-1:0] meta;
  logic [W-1:0] sync;
  logic [W-1:0] prev;

  // Refused at elaboration, not at run time
  if (W < 1)
  begin : g_bad_width
    $error("pot_sync: W must be at least 1");
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      meta <= INIT;
      sync <= INIT;
      prev <= INIT;
    end
    else
    begin
      meta <= pins_i;
      sync <= meta;
      prev <= sync;
    end
  end

  // Edges look only at the second stage onward
  assign level_o = sync;
  assign rise_o = sync & ~prev;
  assign fall_o = ~sync & prev;

endmodule: pot_sync

// ==== pot_serial_cmd_ctrl.sv ====
// Serial command decoder, wiper and non-volatile store of a potentiometer
// Operation
// - Bits captured on serial clock rise, select low
// - Command runs when select rises, input closes
// - Frames not 8 or 16 bits are dropped
// - Writes take 16 bits, command then data
// - Copy and read take 8 or 16 bits
// - Decode the two write command bytes
// - Decode copy and read command bytes
// - Write wiper loads data into wiper
// - Write store leaves wiper untouched
// - Wiper holds one of 256 positions
// - Store copied to wiper 5 us after power-up
// - Store starts at mid-scale
// - Standby when select high, after power-up load and read tail
// - Data pin is input while select low
// - Read data out from second clock rise
// - Store busy for at most 20 ms
// - Wiper-to-store copy only on command
`include "pot_map.svh"

module pot_serial_cmd_ctrl
  import pot_pkg::*;
#(
  parameter int BUSY_CYCLES = `POT_BUSY_CYC
) (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic serial_clock_i,
  input wire logic chip_select_n_i,
  input wire logic serial_data_i,
  output logic serial_data_o,
  output logic serial_data_oe_o,
  output logic [7:0] wiper_o,
  output logic [7:0] nv_o,
  output logic busy_o,
  output logic standby_o
);

  if (BUSY_CYCLES < 1 || BUSY_CYCLES >= (1 << `POT_BUSY_W))
  begin : g_bad_busy
    $error("pot_serial_cmd_ctrl: BUSY_CYCLES out of range");
  end

  // ==========================================================
  // Pin synchronisation
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic sclk_rise;
  logic cs_rise;
  logic cs_fall;
  logic sdi;

  pot_sync #(
    .W(3),
    .INIT(3'h2)
  ) u_sync (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .pins_i({serial_data_i, chip_select_n_i, serial_clock_i}),
    .level_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  assign sclk_rise = pin_rise[0];
  assign cs_rise = pin_rise[1];
  assign cs_fall = pin_fall[1];
  assign sdi = pin_lvl[2];

  // ==========================================================
  // Decode helpers
  function automatic logic is_store(input logic [7:0] cmd);
    is_store = (cmd == `POT_CMD_WR_NV) || (cmd == `POT_CMD_CP_W2NV);
  endfunction: is_store

  function automatic logic [7:0] frame_cmd(input logic [15:0] sh,
                                           input logic [4:0] cnt);
    // Long frames carry the command in the first byte
    frame_cmd = (cnt == `POT_LEN_LONG) ? sh[15:8] : sh[7:0];
  endfunction: frame_cmd

  // ==========================================================
  // State
  pot_regs_t r;
  pot_regs_t n;

  always_comb
  begin
    logic [7:0] cmd;
    logic len8;
    logic len16;
    logic [3:0] tnext;
    cmd = frame_cmd(r.shreg, r.bitcnt);
    len8 = (r.bitcnt == `POT_LEN_SHORT);
    len16 = (r.bitcnt == `POT_LEN_LONG);
    tnext = r.txcnt + 4'h1;
    n = r;

    // Store timer runs independently of the link
    if (r.busy)
    begin
      if (r.busycnt <= `POT_BUSY_W'(1))
        n.busy = 1'b0;
      n.busycnt = r.busycnt - `POT_BUSY_W'(1);
    end

    case (r.state)
      ST_BOOT:
      begin
        n.pucnt = r.pucnt + `POT_PU_W'(1);
        if (r.pucnt == `POT_PU_W'(`POT_PU_CYC - 1))
        begin
          n.wiper = r.nv;
          n.state = ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        if (cs_fall)
        begin
          n.state = ST_RX;
          n.shreg = 16'h0000;
          n.bitcnt = 5'h00;
          n.oe = 1'b0;
        end
      end
      ST_RX:
      begin
        if (cs_rise)
        begin
          // Input closes here; a wrong length runs nothing
          n.state = ST_IDLE;
          if (len16 && cmd == `POT_CMD_WR_WIPER)
            n.wiper = r.shreg[7:0];
          else if (len16 && cmd == `POT_CMD_WR_NV && !r.busy)
          begin
            n.nv = r.shreg[7:0];
            n.busy = 1'b1;
            n.busycnt = `POT_BUSY_W'(BUSY_CYCLES);
          end
          else if ((len8 || len16) && cmd == `POT_CMD_CP_W2NV && !r.busy)
          begin
            n.nv = r.wiper;
            n.busy = 1'b1;
            n.busycnt = `POT_BUSY_W'(BUSY_CYCLES);
          end
          else if ((len8 || len16) && cmd == `POT_CMD_CP_NV2W)
            n.wiper = r.nv;
          else if ((len8 || len16) && (cmd == `POT_CMD_RD_NV ||
                   cmd == `POT_CMD_RD_WIPER))
          begin
            n.state = ST_TX;
            n.txreg = (cmd == `POT_CMD_RD_NV) ? r.nv : r.wiper;
            n.txcnt = 4'h0;
            n.sdo = 1'b0;
            n.oe = 1'b1;
          end
        end
        else if (sclk_rise)
        begin
          n.shreg = {r.shreg[14:0], sdi};
          if (r.bitcnt != `POT_LEN_SAT)
            n.bitcnt = r.bitcnt + 5'h01;
        end
      end
      ST_TX:
      begin
        if (cs_fall)
        begin
          n.state = ST_RX;
          n.shreg = 16'h0000;
          n.bitcnt = 5'h00;
          n.oe = 1'b0;
        end
        else if (sclk_rise && r.txcnt != `POT_TX_SLEEP)
        begin
          n.txcnt = tnext;
          if (tnext >= `POT_TX_FIRST && tnext <= `POT_TX_LAST)
          begin
            n.sdo = r.txreg[7];
            n.txreg = {r.txreg[6:0], 1'b0};
          end
        end
      end
      default: n.state = ST_IDLE;
    endcase

    n.standby = (n.state == ST_IDLE) ||
                (n.state == ST_TX && n.txcnt == `POT_TX_SLEEP);
  end

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      r <= '0;
      r.state <= ST_BOOT;
      r.nv <= `POT_FACTORY_POS;
    end
    else
      r <= n;
  end

  assign serial_data_o = r.sdo;
  assign serial_data_oe_o = r.oe;
  assign wiper_o = r.wiper;
  assign nv_o = r.nv;
  assign busy_o = r.busy;
  assign standby_o = r.standby;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  logic exec_ok;
  assign exec_ok = (r.state == ST_RX) && cs_rise;

  property p_len_drop;
    exec_ok && r.bitcnt != `POT_LEN_SHORT && r.bitcnt != `POT_LEN_LONG
      |=> $stable(wiper_o) && $stable(nv_o) && !serial_data_oe_o;
  endproperty
  a_len_drop: assert property (p_len_drop)
    else $error("bad length frame changed state");

  property p_wr_wiper;
    exec_ok && r.bitcnt == `POT_LEN_LONG && r.shreg[15:8] == 8'h00
      |=> wiper_o == $past(r.shreg[7:0]) && standby_o;
  endproperty
  a_wr_wiper: assert property (p_wr_wiper)
    else $error("wiper write lost");

  property p_wr_nv;
    exec_ok && r.bitcnt == `POT_LEN_LONG && r.shreg[15:8] == 8'h10 &&
      !r.busy |=> nv_o == $past(r.shreg[7:0]) && busy_o && $stable(wiper_o);
  endproperty
  a_wr_nv: assert property (p_wr_nv)
    else $error("store write wrong");

  property p_busy_block;
    exec_ok && r.busy && r.busycnt > `POT_BUSY_W'(1) &&
      is_store(frame_cmd(r.shreg, r.bitcnt)) |=> $stable(nv_o);
  endproperty
  a_busy_block: assert property (p_busy_block)
    else $error("store accepted while busy");

  property p_copy_in;
    exec_ok && r.bitcnt == `POT_LEN_SHORT && r.shreg[7:0] == 8'h30
      |=> wiper_o == $past(nv_o);
  endproperty
  a_copy_in: assert property (p_copy_in)
    else $error("store-to-wiper copy wrong");

  property p_rx_input;
    r.state == ST_RX |-> !serial_data_oe_o;
  endproperty
  a_rx_input: assert property (p_rx_input)
    else $error("pin driven while select low");

  property p_first_bit;
    r.state == ST_TX && sclk_rise && !cs_fall && r.txcnt == 4'h1
      |=> serial_data_o == $past(r.txreg[7]) && serial_data_oe_o;
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("first read bit wrong");

  property p_sleep;
    r.state == ST_TX && sclk_rise && !cs_fall && r.txcnt == 4'ha
      |=> standby_o ##1 standby_o;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("standby not entered after read");

  property p_boot;
    r.state == ST_BOOT && r.pucnt == `POT_PU_W'(`POT_PU_CYC - 1)
      |=> wiper_o == nv_o && r.state == ST_IDLE;
  endproperty
  a_boot: assert property (p_boot)
    else $error("power-up load wrong");

  property p_busy_len;
    $rose(busy_o) |-> busy_o [*8];
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy dropped early");

  c_write: cover property (exec_ok && r.bitcnt == `POT_LEN_LONG);
  c_read: cover property (r.state == ST_TX && r.txcnt == `POT_TX_SLEEP);
  c_short: cover property (exec_ok && r.bitcnt == `POT_LEN_SHORT);
  c_bad: cover property (exec_ok && r.bitcnt == 5'h07);

endmodule: pot_serial_cmd_ctrl

// ==== pot_host_model.sv ====
// Host controller model driving the three-wire serial link
module pot_host_model (
  output logic sclk_o,
  output logic csn_o,
  output logic sd_o,
  output logic sd_oe_o,
  input wire logic sd_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    sclk_o = 1'b0;
    csn_o = 1'b1;
    sd_o = 1'b0;
    sd_oe_o = 1'b0;
  end
  // ==========================================================
  // Frames; link clock stands still low between them
  task automatic frame(input int n, input logic [15:0] w);
    csn_o = 1'b0;
    sd_oe_o = 1'b1;
    #100;
    for (int i = 0; i < n; i++)
    begin
      sd_o = w[15 - (i % 16)];
      #62.5 sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
    end
    #100 csn_o = 1'b1;
    sd_oe_o = 1'b0;
    sd_o = ~sd_o;
    #250;
  endtask: frame
  // Sampled late in the high phase, after the sync delay
  task automatic read(output logic [7:0] v);
    for (int k = 1; k <= 11; k++)
    begin
      #62.5 sclk_o = 1'b1;
      #60;
      if (k >= 2 && k <= 9)
        v[9 - k] = sd_i;
      #2.5 sclk_o = 1'b0;
    end
  endtask: read
endmodule: pot_host_model

// ==== pot_serial_cmd_ctrl_tb.sv ====
// Self-checking bench of the potentiometer serial command controller
module pot_serial_cmd_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {int n; logic [15:0] w; logic [7:0] ew, env;} pot_row_t;
  logic clock_i, srst_i, sclk, chip_select_n, hd, hoe, so, soe, busy, stby;
  logic idle_lvl = 1'b0;
  logic [7:0] wiper, nv, rv;
  wire sdio;
  int n_fail = 0;
  int tests_run = 0;
  pot_row_t rows [15] = '{'{16, 16'h0000, 8'h00, 8'h80},
    '{16, 16'h00ff, 8'hff, 8'h80}, '{16, 16'h105a, 8'hff, 8'h5a},
    '{8, 16'h3000, 8'h5a, 8'h5a}, '{16, 16'h00a5, 8'ha5, 8'h5a},
    '{16, 16'h20c3, 8'ha5, 8'ha5}, '{8, 16'h0011, 8'ha5, 8'ha5},
    '{7, 16'h0012, 8'ha5, 8'ha5}, '{9, 16'h0013, 8'ha5, 8'ha5},
    '{15, 16'h0014, 8'ha5, 8'ha5}, '{17, 16'h0015, 8'ha5, 8'ha5},
    '{16, 16'h0133, 8'ha5, 8'ha5}, '{16, 16'h103c, 8'ha5, 8'h3c},
    '{16, 16'h30ff, 8'h3c, 8'h3c}, '{16, 16'h0096, 8'h96, 8'h3c}};
  // Released pin shows the inverse of its last level
  assign sdio = soe ? so : (hoe ? hd : idle_lvl);
  always @(posedge clock_i)
    if (soe | hoe)
      idle_lvl <= ~sdio;
  pot_serial_cmd_ctrl #(.BUSY_CYCLES(400)) i_pot_serial_cmd_ctrl (
    .clock_i(clock_i), .srst_i(srst_i), .serial_clock_i(sclk),
    .chip_select_n_i(chip_select_n), .serial_data_i(sdio), .serial_data_o(so),
    .serial_data_oe_o(soe), .wiper_o(wiper), .nv_o(nv), .busy_o(busy),
    .standby_o(stby));
  pot_host_model i_pot_host_model (.sclk_o(sclk), .csn_o(chip_select_n), .sd_o(hd),
    .sd_oe_o(hoe), .sd_i(sdio));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask: chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask: conclude
  task automatic do_reset();
    @(posedge clock_i);
    srst_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    srst_i <= 1'b0;
  endtask: do_reset
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 2000)
    begin
      @(posedge clock_i);
      k++;
    end
    chk("busy", 8'h00, {7'h0, busy});
  endtask: wait_idle
  // ==========================================================
  // Clock, watchdog, main sequence
  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  initial
  begin
    #400000;
    n_fail++;
    conclude();
  end
  initial
  begin
    srst_i = 1'b1;
    do_reset();
    repeat (600) @(posedge clock_i);
    chk("boot wiper", 8'h00, wiper);
    repeat (50) @(posedge clock_i);
    chk("boot wiper", 8'h80, wiper);
    chk("boot nv", 8'h80, nv);
    chk("standby", 8'h01, {7'h0, stby});
    foreach (rows[i])
    begin
      i_pot_host_model.frame(rows[i].n, rows[i].w);
      wait_idle();
      chk("wiper", rows[i].ew, wiper);
      chk("nv", rows[i].env, nv);
    end
    i_pot_host_model.frame(8, 16'h6800);
    i_pot_host_model.read(rv);
    chk("read wiper", 8'h96, rv);
    chk("drive", 8'h01, {7'h0, soe});
    repeat (10) @(posedge clock_i);
    chk("standby", 8'h01, {7'h0, stby});
    chk("wiper", 8'h96, wiper);
    fork
      i_pot_host_model.frame(16, 16'h28ff);
      begin
        #400;
        chk("drive", 8'h00, {7'h0, soe});
        chk("standby", 8'h00, {7'h0, stby});
      end
    join
    i_pot_host_model.read(rv);
    chk("read nv", 8'h3c, rv);
    i_pot_host_model.frame(16, 16'h1011);
    chk("busy", 8'h01, {7'h0, busy});
    i_pot_host_model.frame(16, 16'h1022);
    wait_idle();
    chk("nv", 8'h11, nv);
    chk("wiper", 8'h96, wiper);
    do_reset();
    repeat (650) @(posedge clock_i);
    chk("reset wiper", 8'h80, wiper);
    conclude();
  end
endmodule: pot_serial_cmd_ctrl_tb
